// [logic/csm_channel_slot_mapper.v]
// Top of the channel slot mapper: APB register slave, frame tracking on the
// sampled bit clock and frame sync, and the slot-steered serial data output.
// Assumes BCLK and FSYNC come from the far side with no relation to CLK_SYS,
// which must run at least eight times faster than BCLK; the channel samples
// come from logic on CLK_SYS and are captured at each frame start.
`timescale 1ns/100ps
`include "csm_defines.vh"

module csm_channel_slot_mapper
(
   // Clock and reset
   input wire                     CLK_SYS,
   input wire                     ARST_N,
   // APB slave
   input wire                     PSEL,
   input wire                     PENABLE,
   input wire                     PWRITE,
   input wire [`CSM_ADDR_W-1:0]   PADDR,
   input wire [31:0]              PWDATA,
   output reg [31:0]              PRDATA,
   output reg                     PREADY,
   output reg                     PSLVERR,
   // Channel samples
   input wire [`CSM_SAMPLE_W-1:0] CH1_SAMPLE,
   input wire [`CSM_SAMPLE_W-1:0] CH2_SAMPLE,
   input wire [`CSM_SAMPLE_W-1:0] CH3_SAMPLE,
   input wire [`CSM_SAMPLE_W-1:0] CH4_SAMPLE,
   // Serial audio port
   input wire                     BCLK,
   input wire                     FSYNC,
   output reg                     SDOUT,
   output reg                     SDOUT_OE_N,
   output reg                     FRAME_START
);

   // Registers.
   reg [`CSM_SLOT_W-1:0]    first_channel_slot_code_q;
   reg [`CSM_SLOT_W-1:0]    second_channel_slot_code_q;
   reg [`CSM_SLOT_W-1:0]    third_channel_slot_code_q;
   reg [`CSM_SLOT_W-1:0]    fourth_channel_slot_code_q;
   reg [1:0]                fmt_q;
   reg [4:0]                offset_q;

   // Synchronisers and frame state.
   reg                      bclk_s1_q;
   reg                      bclk_s2_q;
   reg                      bclk_s3_q;
   reg                      fsync_s1_q;
   reg                      fsync_s2_q;
   reg                      fs_prev_q;
   reg [`CSM_CNT_W-1:0]     bit_cnt_q;
   reg [`CSM_LEN_W-1:0]     frame_len_q;
   reg [`CSM_LEN_W-1:0]     half_len_q;
   reg [`CSM_SAMPLE_W-1:0]  smp1_q;
   reg [`CSM_SAMPLE_W-1:0]  smp2_q;
   reg [`CSM_SAMPLE_W-1:0]  smp3_q;
   reg [`CSM_SAMPLE_W-1:0]  smp4_q;

   // Bus decode.
   wire [5:0]               idx;
   wire                     word_ok;
   wire                     setup;
   wire                     wr_en;
   reg                      mapped;
   reg [31:0]               rd_d;

   // Frame tracking.
   wire                     bclk_rise;
   wire                     bclk_fall;
   wire                     fs_rise;
   wire                     fs_fall;
   wire                     start_edge;
   wire                     mid_edge;
   wire                     tdm;
   wire                     left_just_fmt;
   wire [`CSM_LEN_W-1:0]    dly;
   wire [`CSM_LEN_W-1:0]    cnt_ext;
   wire [`CSM_LEN_W-1:0]    pos;
   wire [`CSM_LEN_W-1:0]    next_cnt;

   // Slot location of the current bit time.
   reg                      right_half;
   reg [`CSM_LEN_W-1:0]     reg_start;
   reg [`CSM_LEN_W-1:0]     reg_len;
   wire [`CSM_LEN_W-1:0]    rel;
   wire [`CSM_LEN_W-1:0]    slot_end;
   wire [`CSM_LEN_W-1:0]    last_bit;
   wire                     fits;
   wire                     line_valid;
   wire [`CSM_SLOT_W-1:0]   line_slot;
   wire [`CSM_BIT_IDX_W-1:0] line_bit;
   wire [3:0]               hit;
   wire [3:0]               dat;
   wire                     out_hit;
   wire                     out_dat;

   // APB: zero-wait answer registered in the setup cycle.
   assign idx     = PADDR[7:2];
   assign word_ok = (PADDR[1:0] == 2'h0);
   assign setup   = PSEL & ~PENABLE;
   assign wr_en   = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

   always @*
   begin
      mapped = word_ok;
      rd_d   = 32'h0000_0000;
      case (idx)
         `CSM_IDX_CH1:
            rd_d = {26'h0, first_channel_slot_code_q};
         `CSM_IDX_CH2:
            rd_d = {26'h0, second_channel_slot_code_q};
         `CSM_IDX_CH3:
            rd_d = {26'h0, third_channel_slot_code_q};
         `CSM_IDX_CH4:
            rd_d = {26'h0, fourth_channel_slot_code_q};
         `CSM_IDX_CFG:
            rd_d = {19'h0, offset_q, 6'h0, fmt_q};
         `CSM_IDX_STS:
            rd_d = {4'h0, half_len_q, 4'h0, frame_len_q};
         default:
            mapped = 1'b0;
      endcase
   end

   always @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY  <= setup;
         PSLVERR <= setup & ~mapped;
         if (setup)
         begin
            PRDATA <= (~PWRITE & mapped) ? rd_d : 32'h0000_0000;
         end
      end
   end

   // Slot registers: only the six code bits are stored.
   always @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         first_channel_slot_code_q  <= `CSM_CH1_RST;
         second_channel_slot_code_q <= `CSM_CH2_RST;
         third_channel_slot_code_q  <= `CSM_CH3_RST;
         fourth_channel_slot_code_q <= `CSM_CH4_RST;
         fmt_q                      <= `CSM_CFG_FMT_RST;
         offset_q                   <= `CSM_CFG_OFS_RST;
      end
      else if (wr_en)
      begin
         case (idx)
            `CSM_IDX_CH1:
               first_channel_slot_code_q <=
                  PWDATA[`CSM_SLOT_MSB:0];
            `CSM_IDX_CH2:
               second_channel_slot_code_q <=
                  PWDATA[`CSM_SLOT_MSB:0];
            `CSM_IDX_CH3:
               third_channel_slot_code_q <=
                  PWDATA[`CSM_SLOT_MSB:0];
            `CSM_IDX_CH4:
               fourth_channel_slot_code_q <=
                  PWDATA[`CSM_SLOT_MSB:0];
            `CSM_IDX_CFG:
            begin
               fmt_q    <= PWDATA[`CSM_CFG_FMT_MSB:`CSM_CFG_FMT_LSB];
               offset_q <= PWDATA[`CSM_CFG_OFS_MSB:`CSM_CFG_OFS_LSB];
            end
            default:
               fmt_q <= fmt_q;
         endcase
      end
   end

   // Pin synchronisers; bit clock edges are found only between the second and third
   // stages so the first stage feeds nothing but the second.
   always @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         bclk_s1_q  <= 1'b0;
         bclk_s2_q  <= 1'b0;
         bclk_s3_q  <= 1'b0;
         fsync_s1_q <= 1'b0;
         fsync_s2_q <= 1'b0;
      end
      else
      begin
         bclk_s1_q  <= BCLK;
         bclk_s2_q  <= bclk_s1_q;
         bclk_s3_q  <= bclk_s2_q;
         fsync_s1_q <= FSYNC;
         fsync_s2_q <= fsync_s1_q;
      end
   end

   assign bclk_rise     = bclk_s2_q & ~bclk_s3_q;
   assign bclk_fall     = ~bclk_s2_q & bclk_s3_q;
   assign fs_rise       = ~fs_prev_q & fsync_s2_q;
   assign fs_fall       = fs_prev_q & ~fsync_s2_q;
   assign tdm           = (fmt_q == `CSM_FMT_TDM);
   assign left_just_fmt = (fmt_q == `CSM_FMT_LJ);
   // I2S opens the left half on a falling sync; the others on a rising one.
   assign start_edge    = (fmt_q == `CSM_FMT_I2S) ? fs_fall : fs_rise;
   assign mid_edge      = (fmt_q == `CSM_FMT_I2S) ? fs_rise : fs_fall;
   assign next_cnt      = {1'b0, bit_cnt_q} + 12'h001;

   // Frame and half lengths are measured on the previous frame, so the
   // first frame after sync is seen carries no data.
   always @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         fs_prev_q   <= 1'b0;
         bit_cnt_q   <= {`CSM_CNT_W{1'b0}};
         frame_len_q <= {`CSM_LEN_W{1'b0}};
         half_len_q  <= {`CSM_LEN_W{1'b0}};
         smp1_q      <= {`CSM_SAMPLE_W{1'b0}};
         smp2_q      <= {`CSM_SAMPLE_W{1'b0}};
         smp3_q      <= {`CSM_SAMPLE_W{1'b0}};
         smp4_q      <= {`CSM_SAMPLE_W{1'b0}};
         FRAME_START <= 1'b0;
      end
      else
      begin
         FRAME_START <= bclk_rise & start_edge;
         if (bclk_rise)
         begin
            fs_prev_q <= fsync_s2_q;
            if (start_edge)
            begin
               bit_cnt_q   <= {`CSM_CNT_W{1'b0}};
               frame_len_q <= next_cnt;
               smp1_q      <= CH1_SAMPLE;
               smp2_q      <= CH2_SAMPLE;
               smp3_q      <= CH3_SAMPLE;
               smp4_q      <= CH4_SAMPLE;
            end
            else
            begin
               if (bit_cnt_q != {`CSM_CNT_W{1'b1}})
               begin
                  bit_cnt_q <= next_cnt[`CSM_CNT_W-1:0];
               end
               if (mid_edge)
               begin
                  half_len_q <= next_cnt;
               end
            end
         end
      end
   end

   // Bit position after the protocol delay and the programmed offset.
   assign dly     = (fmt_q == `CSM_FMT_I2S) ? `CSM_I2S_DELAY
                                             : `CSM_STD_DELAY;
   assign cnt_ext = {1'b0, bit_cnt_q};
   assign pos     = cnt_ext - {7'h00, offset_q} - dly;

   always @*
   begin
      right_half = 1'b0;
      reg_start  = {`CSM_LEN_W{1'b0}};
      reg_len    = frame_len_q;
      if (!tdm)
      begin
         if (pos < half_len_q)
         begin
            reg_len = half_len_q;
         end
         else
         begin
            right_half = 1'b1;
            reg_start  = half_len_q;
            reg_len    = frame_len_q - half_len_q;
         end
      end
   end

   assign rel        = pos - reg_start;
   assign slot_end   = {1'b0, rel[10:5], 5'h1f};
   assign last_bit   = reg_start + slot_end + {7'h00, offset_q} + dly;
   // A slot goes out whole or not at all, never cut by a region or frame end.
   assign fits       = (slot_end < reg_len)
                     & (last_bit < frame_len_q);
   assign line_valid = ~pos[`CSM_LEN_W-1] & fits & (tdm | ~rel[10]);
   assign line_slot  = tdm ? rel[10:5]
                           : {right_half, rel[9:5]};
   assign line_bit   = rel[4:0];

   csm_slot_match u_match1
   (
      .slot_code  (first_channel_slot_code_q),
      .sample     (smp1_q),
      .line_valid (line_valid),
      .line_slot  (line_slot),
      .line_bit   (line_bit),
      .hit        (hit[0]),
      .data       (dat[0])
   );

   csm_slot_match u_match2
   (
      .slot_code  (second_channel_slot_code_q),
      .sample     (smp2_q),
      .line_valid (line_valid),
      .line_slot  (line_slot),
      .line_bit   (line_bit),
      .hit        (hit[1]),
      .data       (dat[1])
   );

   csm_slot_match u_match3
   (
      .slot_code  (third_channel_slot_code_q),
      .sample     (smp3_q),
      .line_valid (line_valid),
      .line_slot  (line_slot),
      .line_bit   (line_bit),
      .hit        (hit[2]),
      .data       (dat[2])
   );

   csm_slot_match u_match4
   (
      .slot_code  (fourth_channel_slot_code_q),
      .sample     (smp4_q),
      .line_valid (line_valid),
      .line_slot  (line_slot),
      .line_bit   (line_bit),
      .hit        (hit[3]),
      .data       (dat[3])
   );

   // Two channels on one slot would fight; the lower channel wins.
   assign out_hit = |hit;
   assign out_dat = hit[0] ? dat[0]
                  : hit[1] ? dat[1]
                  : hit[2] ? dat[2]
                  : (hit[3] & dat[3]);

   // Data changes after the falling bit clock so the far side can sample
   // on the rising one.
   always @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         SDOUT      <= 1'b0;
         SDOUT_OE_N <= 1'b1;
      end
      else if (bclk_fall)
      begin
         SDOUT      <= out_dat;
         SDOUT_OE_N <= ~out_hit;
      end
   end

endmodule // csm_channel_slot_mapper

// [logic/csm_defines.vh]
// Constants of the channel slot mapper: register indices, field positions,
// reset values and framing constants.
// Assumes inclusion by bare name from the mapper's design files.
`ifndef CSM_DEFINES_VH
`define CSM_DEFINES_VH

// Register indices; the byte address is four times the index.
`define CSM_IDX_CH1          6'h0b
`define CSM_IDX_CH2          6'h0c
`define CSM_IDX_CH3          6'h0d
`define CSM_IDX_CH4          6'h0e
`define CSM_IDX_CFG          6'h10
`define CSM_IDX_STS          6'h11
`define CSM_ADDR_W           8

// Slot register layout and reset values.
`define CSM_SLOT_MSB         5
`define CSM_SLOT_W           6
`define CSM_CH1_RST          6'h00
`define CSM_CH2_RST          6'h01
`define CSM_CH3_RST          6'h02
`define CSM_CH4_RST          6'h03

// Configuration register layout.
`define CSM_CFG_FMT_LSB      0
`define CSM_CFG_FMT_MSB      1
`define CSM_CFG_OFS_LSB      8
`define CSM_CFG_OFS_MSB      12
`define CSM_CFG_FMT_RST      2'h0
`define CSM_CFG_OFS_RST      5'h00

// Frame formats.
`define CSM_FMT_TDM          2'h0
`define CSM_FMT_I2S          2'h1
`define CSM_FMT_LJ           2'h2

// Framing.
`define CSM_SAMPLE_W         32
`define CSM_BIT_IDX_W        5
`define CSM_CNT_W            11
`define CSM_LEN_W            12
`define CSM_I2S_DELAY        12'h001
`define CSM_STD_DELAY        12'h000

`endif

// [logic/csm_slot_match.v]
// One channel's slot comparator: flags a hit when the slot now on the line
// equals the channel's code, and picks the sample bit for that bit time.
// Assumes the caller gives a sample word that is steady through the frame.
`timescale 1ns/100ps
`include "csm_defines.vh"

module csm_slot_match
(
   // Channel setting
   input wire [`CSM_SLOT_W-1:0]    slot_code,
   input wire [`CSM_SAMPLE_W-1:0]  sample,
   // Line position
   input wire                      line_valid,
   input wire [`CSM_SLOT_W-1:0]    line_slot,
   input wire [`CSM_BIT_IDX_W-1:0] line_bit,
   // Result
   output wire                     hit,
   output wire                     data
);

   wire [`CSM_BIT_IDX_W-1:0] msb_first;

   // Samples go out MSB first.
   assign msb_first = ~line_bit;
   assign hit       = line_valid & (slot_code == line_slot);
   assign data      = sample[msb_first];

endmodule // csm_slot_match

// [verification/csm_assertions.sv]
// Port checker for the channel slot mapper: APB answers and serial timing.
// Assumes it is bound to the mapper top and sees only that module's ports.
`timescale 1ns/100ps

module csm_assertions
(
   // Clock and reset
   input wire        CLK_SYS,
   input wire        ARST_N,
   // APB slave
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [7:0]  PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   // Serial port
   input wire        BCLK,
   input wire        SDOUT_OE_N,
   input wire        FRAME_START
);
   logic [5:0] shd_q [0:3];
   logic       bclk_q;
   logic [2:0] fall_cnt_q;
   wire  [5:0] idx = PADDR[7:2] - 6'h0b;
   wire        acc = PSEL && PENABLE && PREADY;
   wire        slot_acc = acc && PADDR[1:0] == 2'h0 && idx <= 6'h03;

   // The counter saturates so that a stopped bit clock never wraps it.
   always_ff @(posedge CLK_SYS or negedge ARST_N)
      if (!ARST_N)
      begin
         shd_q <= '{6'h00, 6'h01, 6'h02, 6'h03};
         bclk_q <= 1'b0;
         fall_cnt_q <= 3'h7;
      end
      else
      begin
         if (slot_acc && PWRITE)
            shd_q[idx[1:0]] <= PWDATA[5:0];
         bclk_q <= BCLK;
         if (bclk_q && !BCLK)
            fall_cnt_q <= 3'h0;
         else if (fall_cnt_q != 3'h7)
            fall_cnt_q <= fall_cnt_q + 3'h1;
      end

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   setup_answer_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no answer after setup");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   unaligned_err_a: assert property (acc && PADDR[1:0] != 2'h0 |-> PSLVERR)
      else $error("unaligned access not refused");
   err_read_zero_a: assert property (acc && PSLVERR && !PWRITE |-> !PRDATA)
      else $error("refused read not zero");
   slot_ok_a: assert property (slot_acc |-> !PSLVERR)
      else $error("slot register refused");
   rsv_bits_zero_a: assert property (
      slot_acc && !PWRITE |-> PRDATA[31:6] == 26'h0)
      else $error("upper slot bits not zero");
   slot_readback_a: assert property (
      slot_acc && !PWRITE |-> PRDATA[5:0] == shd_q[idx[1:0]])
      else $error("slot code readback wrong");
   start_pulse_a: assert property (FRAME_START |=> !FRAME_START [*7])
      else $error("frame start pulse too long");
   drive_edge_a: assert property ($changed(SDOUT_OE_N) |-> fall_cnt_q <= 3'h5)
      else $error("drive change away from falling edge");

   cover property (acc && PSLVERR);
   cover property (FRAME_START);
   cover property ($fell(SDOUT_OE_N));
endmodule // csm_assertions

bind csm_channel_slot_mapper csm_assertions i_chk
(
   .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .BCLK(BCLK),
   .SDOUT_OE_N(SDOUT_OE_N), .FRAME_START(FRAME_START)
);

// [verification/csm_host_model.sv]
// Host model at the far side: makes bit clock and frame sync, samples data.
// Assumes the mapper drives after falling edges; the host samples on rising.
`timescale 1ns/100ps

module csm_host_model
(
   // Serial port
   output logic BCLK,
   output logic FSYNC,
   input  wire  SDOUT,
   input  wire  SDOUT_OE_N
);
   logic [1:0] cap_q [0:2047];

   initial
   begin
      BCLK = 1'b0;
      FSYNC = 1'b0;
   end

   // One extra rise after the frames catches the last bit; the clock then
   // stands still low. The 37 ns skew keeps edges off the system clock.
   task automatic frames(input int n, input int len, input int fmt);
      int k;
      #37;
      for (int j = 0; j <= n * len; j++)
      begin
         k = j % len;
         if (j < n * len)
            FSYNC = (fmt == 0) ? k == 0 : (fmt == 1) == (k >= len / 2);
         #400 BCLK = 1'b1;
         cap_q[(k + len - 1) % len] = (SDOUT_OE_N === 1'b1) ? 2'b00
                                      : {!SDOUT_OE_N, SDOUT};
         #400 BCLK = 1'b0;
      end
   endtask
endmodule // csm_host_model

// [verification/csm_testbench.sv]
// Self-checking bench: slot registers over APB and slot placement on link.
// Assumes the host model drives the link and samples the serial data.
`timescale 1ns/100ps

module testbench;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, bclk, fsync, sdout, oe_n, e;
   logic [31:0] smp [0:3] = '{default: 32'h0};
   logic [5:0]  code [0:3] = '{6'h00, 6'h01, 6'h02, 6'h03};
   logic [31:0] r;
   int          n_fail = 0, compares = 0;

   always #50 clk = ~clk;

   csm_channel_slot_mapper i_dut
   (
      .CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .CH1_SAMPLE(smp[0]),
      .CH2_SAMPLE(smp[1]), .CH3_SAMPLE(smp[2]), .CH4_SAMPLE(smp[3]),
      .BCLK(bclk), .FSYNC(fsync), .SDOUT(sdout), .SDOUT_OE_N(oe_n),
      .FRAME_START()
   );

   csm_host_model i_host
   (
      .BCLK(bclk), .FSYNC(fsync), .SDOUT(sdout), .SDOUT_OE_N(oe_n)
   );

   task automatic stop_test;
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(r, x);
      chk(e, xe);
   endtask

   // Lowest channel wins a shared slot; a slot that would be cut by its
   // region or by the frame end stays undriven.
   function automatic logic [1:0] exp_bit(int fmt, int len, int ofs, int c);
      int h, base, p, s, d;
      d = (fmt == 1);
      h = (fmt == 0) ? len : len / 2;
      p = c - ofs - d;
      base = (fmt != 0 && p >= h) ? h : 0;
      s = (p - base) / 32;
      if (p < 0 || s * 32 + 31 >= ((base != 0) ? len - h : h)
          || base + s * 32 + 31 + ofs + d >= len)
         return 2'b00;
      for (int ch = 0; ch < 4; ch++)
         if (code[ch] == s + ((base != 0) ? 32 : 0))
            return {1'b1, smp[ch][31 - (p - base) % 32]};
      return 2'b00;
   endfunction

   // Only the third frame is judged: the first two set up measured lengths.
   task automatic frame_test(input int fmt, input int len, input int ofs);
      for (int ch = 0; ch < 4; ch++)
      begin
         smp[ch] <= $urandom;
         apb(1'b1, 8'(44 + 4 * ch), {26'h0, code[ch]});
      end
      apb(1'b1, 8'h40, 32'(ofs << 8 | fmt));
      i_host.frames(3, len, fmt);
      for (int c = 0; c < len; c++)
         chk(i_host.cap_q[c], exp_bit(fmt, len, ofs, c));
   endtask

   initial
   begin
      void'($urandom(46));
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      for (int ch = 0; ch < 4; ch++)
         rdc(8'(44 + 4 * ch), ch, 1'b0);
      apb(1'b1, 8'h30, 32'h0000_003f);
      rdc(8'h30, 32'h3f, 1'b0);
      rdc(8'h00, 32'h0, 1'b1);
      rdc(8'h2d, 32'h0, 1'b1);
      code = '{6'h00, 6'h01, 6'h02, 6'h03};
      frame_test(0, 256, 0);
      code = '{6'h3f, 6'h3e, 6'h05, 6'h3f};
      frame_test(0, 2048, 0);
      code = '{6'h20, 6'h01, 6'h21, 6'h22};
      frame_test(1, 192, 0);
      rdc(8'h44, 32'h0060_00c0, 1'b0);
      code = '{6'h21, 6'h00, 6'h20, 6'h01};
      frame_test(2, 192, 5);
      frame_test(0, 128, 31);
      repeat (2)
      begin
         for (int ch = 0; ch < 4; ch++)
            code[ch] = 6'($urandom % 8);
         frame_test(0, 256, $urandom % 32);
      end
      stop_test;
   end

   initial
   begin
      #9500000;
      n_fail++;
      stop_test;
   end
endmodule // testbench
